// ### design/sector_status_regs.sv
/*
  Sector selection/status registers, program data registers and event
  interrupt for an on-chip flash write controller.
  Assumes the controller sequencer (start bits, address registers, error
  register, busy flags) sits outside and reports through CTL_* ports.
  Register port: word offsets from the package, a write takes effect at the
  strobe edge, read data stands only in the cycle after the read strobe and
  reads zero otherwise; the port never stalls the master.
  The sequencer holds CTL_ERASE_RUN and CTL_SUSPEND as levels and pulses
  CTL_OP_DONE for one cycle with CTL_OP_ERASE and CTL_ERR beside it.
  Interrupt: sticky status, write-one clear, enable of the same layout,
  one level output.
*/
// Contract
// - erase sets low bits as sector status
// - clean write end clears low status bits
// - low bits 11:10 mirror high bits 1:0
// - erase sets high bits 1:0 as status
// - erase updates bank status bit 8
// - clean erase end clears bank status
// - bit 9 always duplicates bank status
// - erase flag set: bits mean error
// - suspend only: bits mean suspended
// - program uses address and data registers
`timescale 1ns/10ps
`default_nettype none
module sector_status_regs
  import sector_regs_pkg::*;
(
  input  wire logic              REF_CLK,      // 250 MHz clock
  input  wire logic              SYS_RST,      // synchronous reset, high
  input  wire logic [ADDR_W-1:0] REG_ADDR,     // register address
  input  wire logic [DATA_W-1:0] REG_WDATA,    // write data
  input  wire logic              REG_WR,       // write strobe
  input  wire logic              REG_RD,       // read strobe
  output logic      [DATA_W-1:0] REG_RDATA,    // read data, cycle after strobe
  input  wire logic              CTL_ERASE_RUN,// erase in progress
  input  wire logic              CTL_SUSPEND,  // erase suspended
  input  wire logic              CTL_OP_DONE,  // write ended, one cycle
  input  wire logic              CTL_OP_ERASE, // ended op was an erase
  input  wire logic              CTL_ERR,      // error detected
  input  wire logic [SECTORS-1:0] CTL_SECT_FAIL,// per-sector marks
  output logic      [31:0]       PROG_WORD0,   // first program word
  output logic      [15:0]       PROG_WORD1_LOW,// second word, low half
  output logic      [SECTORS-1:0] ERASE_SEL,   // sectors selected for erase
  output logic                   IRQ           // level interrupt
);

  reg_req_t          req;
  ctl_status_t       ctl;
  prog_data_t        prog;
  logic [SECTORS-1:0] sel;          // software selection
  logic [SECTORS-1:0] sect_stat;    // hardware sector status
  logic               bank_stat;    // hardware bank status
  logic [15:0]        data0_low;
  logic [15:0]        data0_high;
  logic [15:0]        data1_low;
  logic [IRQ_W-1:0]   irq_status;
  logic [IRQ_W-1:0]   irq_enable;
  logic [IRQ_W-1:0]   irq_event;
  logic [15:0]        next_rdata;
  logic [15:0]        low_view;
  logic [15:0]        high_view;
  logic               suspend_q;

  assign req = '{addr: REG_ADDR, wdata: REG_WDATA, wr: REG_WR, rd: REG_RD};
  assign ctl = '{erase_run: CTL_ERASE_RUN, suspend: CTL_SUSPEND, op_done: CTL_OP_DONE,
                 op_is_erase: CTL_OP_ERASE, err: CTL_ERR, sect_fail: CTL_SECT_FAIL};

  // software selection; low 11:10 and high 1:0 are the same two flops
  // a selection write beats the clean-end clear in the same cycle, so a
  // selection made right at the end of one operation is not lost
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      sel <= RST_SECT;
    end else if (req.wr && req.addr == OFS_SEL_LOW) begin
      sel[LOW_SECT_W-1:0] <= req.wdata[LOW_SECT_W-1:0];
      sel[SECTORS-1:LOW_SECT_W] <= req.wdata[LOW_MIRROR_LSB+1:LOW_MIRROR_LSB];
    end else if (req.wr && req.addr == OFS_SEL_HIGH) begin
      sel[SECTORS-1:LOW_SECT_W] <= req.wdata[1:0];
    end else if (ctl.op_done && !ctl.err) begin
      sel <= RST_SECT;
    end
  end

  // selection writes land whole; an error end leaves the selection alone
  sel_write_low_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (req.wr && req.addr == OFS_SEL_LOW) |=> sel == $past(req.wdata[SECTORS-1:0]))
    else $error("low selection write not taken");
  sel_write_high_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (req.wr && req.addr == OFS_SEL_HIGH) |=> (sel[SECTORS-1:LOW_SECT_W] == $past(req.wdata[1:0])
      && sel[LOW_SECT_W-1:0] == $past(sel[LOW_SECT_W-1:0])))
    else $error("high selection write not taken");
  sel_err_keep_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (ctl.op_done && ctl.err && !req.wr) |=> $stable(sel))
    else $error("selection changed after failed write end");

  // hardware sector status: meaning follows erase/suspend indications
  // only selected sectors are captured, so a stray mark from the sequencer on
  // an unselected sector never shows up as an error in the views
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      sect_stat <= RST_SECT;
    end else if (ctl.op_done && !ctl.err) begin
      sect_stat <= RST_SECT;
    end else if (ctl.erase_run || ctl.suspend) begin
      sect_stat <= ctl.sect_fail & sel;
    end
  end

  // status follows the marks while erasing or suspended, and otherwise stands until a clean end clears it
  suspend_track_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (ctl.suspend && !ctl.op_done) |=> (sect_stat == ($past(ctl.sect_fail) & $past(sel))))
    else $error("sector status not tracking suspend");
  high_status_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (ctl.erase_run && !ctl.op_done) |=> (sect_stat[SECTORS-1:LOW_SECT_W] ==
      ($past(ctl.sect_fail[SECTORS-1:LOW_SECT_W]) & $past(sel[SECTORS-1:LOW_SECT_W]))))
    else $error("last two sector status not tracking erase");
  status_idle_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (!ctl.erase_run && !ctl.suspend && !ctl.op_done) |=> ($stable(sect_stat) && $stable(bank_stat)))
    else $error("status moved with no erase activity");

  // bank status is any selected sector mark while erasing; cleared on clean erase end
  // a suspended erase keeps updating the bank bit so software sees the pause
  // even when the sequencer has already dropped its run level
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      bank_stat <= 1'b0;
    end else if (ctl.op_done && ctl.op_is_erase && !ctl.err) begin
      bank_stat <= 1'b0;
    end else if (ctl.erase_run || ctl.suspend) begin
      bank_stat <= |(ctl.sect_fail & sel);
    end
  end

  // a program end leaves the bank bit; an erase error or suspend with a selected sector marked sets it
  bank_prog_keep_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (ctl.op_done && !ctl.op_is_erase && !ctl.erase_run && !ctl.suspend) |=> $stable(bank_stat))
    else $error("bank status changed at program end");
  bank_error_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (ctl.op_done && ctl.op_is_erase && ctl.err && ctl.erase_run && |(ctl.sect_fail & sel)) |=> bank_stat)
    else $error("bank status lost on erase error");
  bank_suspend_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (ctl.suspend && !ctl.op_done && |(ctl.sect_fail & sel)) |=> bank_stat)
    else $error("bank status not set on suspend");

  // program data holding registers
  // no pairing logic: each half lands on its own write, in any order
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      data0_low  <= RST_REG;
      data0_high <= RST_REG;
      data1_low  <= RST_REG;
    end else if (req.wr) begin
      if (req.addr == OFS_DATA0_LOW)  data0_low  <= req.wdata;
      if (req.addr == OFS_DATA0_HIGH) data0_high <= req.wdata;
      if (req.addr == OFS_DATA1_LOW)  data1_low  <= req.wdata;
    end
  end

  // data handed to the sequencer comes straight from the holding flops
  assign prog = '{word0: {data0_high, data0_low}, word1_low: data1_low, sect_sel: sel};
  assign PROG_WORD0     = prog.word0;
  assign PROG_WORD1_LOW = prog.word1_low;
  assign ERASE_SEL      = prog.sect_sel;

  // data halves land on their own write and otherwise hold
  data0_low_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (req.wr && req.addr == OFS_DATA0_LOW) |=> PROG_WORD0[15:0] == $past(req.wdata))
    else $error("data 0 low not loaded");
  data_hold_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    !req.wr |=> ($stable(PROG_WORD0) && $stable(PROG_WORD1_LOW)))
    else $error("program data moved with no write");

  // register views; reserved bits read zero
  // status ORs onto the selection, so a read cannot tell a selected sector
  // from a marked one; software clears its selection to see pure status
  always_comb begin
    low_view  = '0;
    high_view = '0;
    low_view[SECTORS-1:0]  = sel | sect_stat;
    high_view[1:0]         = sel[SECTORS-1:LOW_SECT_W] | sect_stat[SECTORS-1:LOW_SECT_W];
    high_view[HIGH_BANK_POS] = bank_stat;
    high_view[HIGH_DUP_POS]  = bank_stat;
  end

  // read mux; unmapped and write-only offsets read zero
  always_comb begin
    case (req.addr)
      OFS_SEL_LOW:    next_rdata = low_view;
      OFS_SEL_HIGH:   next_rdata = high_view;
      OFS_DATA0_LOW:  next_rdata = data0_low;
      OFS_DATA0_HIGH: next_rdata = data0_high;
      OFS_DATA1_LOW:  next_rdata = data1_low;
      OFS_IRQ_STATUS: next_rdata = {13'h0000, irq_status};
      OFS_IRQ_ENABLE: next_rdata = {13'h0000, irq_enable};
      default:        next_rdata = RST_REG;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      REG_RDATA <= RST_REG;
    end else if (req.rd) begin
      REG_RDATA <= next_rdata;
    end else begin
      REG_RDATA <= RST_REG;
    end
  end

  // read data stands one cycle only; reserved and write-only bits read zero
  rdata_idle_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    !req.rd |=> REG_RDATA == RST_REG)
    else $error("read data stood past its cycle");
  rdata_bank_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (req.rd && req.addr == OFS_SEL_HIGH) |=> REG_RDATA[HIGH_BANK_POS] == $past(bank_stat))
    else $error("bank status read wrong");
  rdata_dup_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (req.rd && req.addr == OFS_SEL_HIGH) |=> REG_RDATA[HIGH_DUP_POS] == REG_RDATA[HIGH_BANK_POS])
    else $error("duplicate bank bit read differs");
  low_resv_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (req.rd && req.addr == OFS_SEL_LOW) |=> REG_RDATA[15:SECTORS] == 4'h0)
    else $error("low register reserved bits not zero");
  high_resv_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (req.rd && req.addr == OFS_SEL_HIGH) |=> (REG_RDATA[15:HIGH_DUP_POS+1] == 6'h00
      && REG_RDATA[HIGH_BANK_POS-1:2] == 6'h00))
    else $error("high register reserved bits not zero");
  wo_read_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (req.rd && req.addr == OFS_IRQ_CLEAR) |=> REG_RDATA == RST_REG)
    else $error("clear register did not read zero");
  rdata_data1_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (req.rd && req.addr == OFS_DATA1_LOW) |=> REG_RDATA == $past(PROG_WORD1_LOW))
    else $error("data 1 low read wrong");

  // suspend level one cycle back, for the rising-edge interrupt event
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      suspend_q   <= 1'b0;
    end else begin
      suspend_q   <= ctl.suspend;
    end
  end

  // event pulses; a suspend counts once on its rising edge, not while it lasts
  always_comb begin
    irq_event = '0;
    irq_event[IRQ_DONE_OK]   = ctl.op_done && !ctl.err;
    irq_event[IRQ_ERASE_ERR] = ctl.op_done && ctl.op_is_erase && ctl.err;
    irq_event[IRQ_SUSPEND]   = ctl.suspend && !suspend_q;
  end

  // sticky status: a new event wins over a clear in the same cycle
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      irq_status <= RST_IRQ;
    end else if (req.wr && req.addr == OFS_IRQ_CLEAR) begin
      irq_status <= (irq_status & ~req.wdata[IRQ_W-1:0]) | irq_event;
    end else begin
      irq_status <= irq_status | irq_event;
    end
  end

  // each event sets its sticky bit; only a clear write drops one
  // set wins over clear, so an event in the clear cycle is never lost
  irq_clean_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (ctl.op_done && !ctl.err) |=> irq_status[IRQ_DONE_OK])
    else $error("clean end event lost");
  irq_erase_err_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (ctl.op_done && ctl.op_is_erase && ctl.err) |=> irq_status[IRQ_ERASE_ERR])
    else $error("erase error event lost");
  irq_suspend_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    $rose(ctl.suspend) |=> irq_status[IRQ_SUSPEND])
    else $error("suspend event lost");
  irq_sticky_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    !(req.wr && req.addr == OFS_IRQ_CLEAR) |=> ((irq_status & $past(irq_status)) == $past(irq_status)))
    else $error("status bit dropped with no clear");
  irq_clear_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (req.wr && req.addr == OFS_IRQ_CLEAR && !ctl.op_done && !ctl.suspend)
      |=> ((irq_status & $past(req.wdata[IRQ_W-1:0])) == 3'h0))
    else $error("status bit not cleared");

  // enable is plain read/write; enabling a bit already set raises the line at once
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      irq_enable <= RST_IRQ;
    end else if (req.wr && req.addr == OFS_IRQ_ENABLE) begin
      irq_enable <= req.wdata[IRQ_W-1:0];
    end
  end

  // level output from flops through one AND-OR (status masked by enable), no decode that could glitch
  assign IRQ = |(irq_status & irq_enable);

  // enable writes land whole; a zero enable drops the line next cycle
  // whatever status is pending
  enable_write_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (req.wr && req.addr == OFS_IRQ_ENABLE) |=> irq_enable == $past(req.wdata[IRQ_W-1:0]))
    else $error("interrupt enable write not taken");
  irq_off_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (req.wr && req.addr == OFS_IRQ_ENABLE && req.wdata[IRQ_W-1:0] == 3'h0) |=> !IRQ)
    else $error("interrupt high with all enables off");

  // checks
  sel_clear_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (ctl.op_done && !ctl.err && !req.wr) |=> (sel == '0 && sect_stat == '0))
    else $error("selection/status not cleared after clean write end");
  bank_clear_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (ctl.op_done && ctl.op_is_erase && !ctl.err) |=> !bank_stat)
    else $error("bank status not cleared after clean erase end");
  bank_dup_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    high_view[HIGH_DUP_POS] == high_view[HIGH_BANK_POS])
    else $error("duplicate bank bit differs");
  mirror_bits_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    low_view[11:10] == high_view[1:0])
    else $error("low 11:10 does not mirror high 1:0");
  sect_status_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (ctl.erase_run && !ctl.op_done) |=> (sect_stat == ($past(ctl.sect_fail) & $past(sel))))
    else $error("sector status not tracking erase");
  bank_status_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (ctl.erase_run && !ctl.op_done && |(ctl.sect_fail & sel)) |=> bank_stat)
    else $error("bank status not set on sector mark");
  data_load_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (req.wr && req.addr == OFS_DATA0_HIGH) |=> PROG_WORD0[31:16] == $past(req.wdata))
    else $error("data 0 high not loaded");
  data1_load_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (req.wr && req.addr == OFS_DATA1_LOW) |=> PROG_WORD1_LOW == $past(req.wdata))
    else $error("data 1 low not loaded");
  read_view_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (req.rd && req.addr == OFS_SEL_LOW) |=> REG_RDATA == $past(low_view))
    else $error("low register read wrong");
  irq_level_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    IRQ == |(irq_status & irq_enable))
    else $error("interrupt level mismatch");

endmodule : sector_status_regs
`default_nettype wire

// ### pkg/sector_regs_pkg.sv
/*
  Package for the sector selection/status and program data register block:
  register offsets, field positions, reset values, carrier structs.
  Assumes a 16-bit register port with word offsets of our own choosing.
*/
package sector_regs_pkg;
  localparam int          ADDR_W          = 4;
  localparam int          DATA_W          = 16;
  // register offsets
  localparam logic [3:0]  OFS_SEL_LOW     = 4'h0;
  localparam logic [3:0]  OFS_SEL_HIGH    = 4'h1;
  localparam logic [3:0]  OFS_DATA0_LOW   = 4'h2;
  localparam logic [3:0]  OFS_DATA0_HIGH  = 4'h3;
  localparam logic [3:0]  OFS_DATA1_LOW   = 4'h4;
  localparam logic [3:0]  OFS_IRQ_STATUS  = 4'h5;
  localparam logic [3:0]  OFS_IRQ_CLEAR   = 4'h6;
  localparam logic [3:0]  OFS_IRQ_ENABLE  = 4'h7;
  // field positions
  localparam int          LOW_SECT_W      = 10;
  localparam int          LOW_MIRROR_LSB  = 10;
  localparam int          HIGH_BANK_POS   = 8;
  localparam int          HIGH_DUP_POS    = 9;
  localparam int          SECTORS         = 12;
  // interrupt status bits
  localparam int          IRQ_W           = 3;
  localparam int          IRQ_DONE_OK     = 0;
  localparam int          IRQ_ERASE_ERR   = 1;
  localparam int          IRQ_SUSPEND     = 2;
  // reset values
  localparam logic [15:0] RST_REG         = 16'h0000;
  localparam logic [11:0] RST_SECT        = 12'h000;
  localparam logic [2:0]  RST_IRQ         = 3'h0;

  // register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

  // controller progress reported into this block
  typedef struct packed {
    logic              erase_run;      // an erase is running
    logic              suspend;        // erase suspended
    logic              op_done;        // one-cycle: write operation ended
    logic              op_is_erase;    // ended operation was an erase
    logic              err;            // error detected in ended operation
    logic [SECTORS-1:0] sect_fail;     // per-sector failure/suspend marks
  } ctl_status_t;

  // data handed to the programming sequencer
  typedef struct packed {
    logic [31:0]       word0;
    logic [15:0]       word1_low;
    logic [SECTORS-1:0] sect_sel;
  } prog_data_t;
endpackage : sector_regs_pkg

// ### testbench/sector_status_regs_tb_top.sv
/*
  Self-checking bench for sector_status_regs: register table rows, then
  suspend, erase-error and clean-erase sequences with the interrupt.
  Assumes one 250 MHz clock and the register port timing of the package.
*/
`timescale 1ns/10ps
`default_nettype none
module sector_status_regs_tb_top;
  import sector_regs_pkg::*;
  typedef struct {logic [3:0] wa; logic [15:0] wd; logic [3:0] ra; logic [15:0] ex;} row_t;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic [3:0]        addr = 4'h0;
  logic [15:0]       wdata = 16'h0000;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic [15:0]       rdata;
  logic              run = 1'b0, susp = 1'b0, done = 1'b0, ers = 1'b0, err = 1'b0;
  logic [11:0]       fail = 12'h000;
  logic [31:0]       word0;
  logic [15:0]       word1;
  logic [11:0]       esel;
  logic              irq;
  int                n_mismatch = 0;
  int                checks = 0;
  int                cycles = 0;
  // write then read back; mirror rows cross between the two selection views
  row_t rows [8] = '{'{4'h0, 16'h03FF, 4'h0, 16'h03FF}, '{4'h0, 16'h0C00, 4'h1, 16'h0003},
                     '{4'h1, 16'h0002, 4'h0, 16'h0800}, '{4'h2, 16'h1234, 4'h2, 16'h1234},
                     '{4'h3, 16'hABCD, 4'h3, 16'hABCD}, '{4'h4, 16'h5678, 4'h4, 16'h5678},
                     '{4'h9, 16'hFFFF, 4'h9, 16'h0000}, '{4'h6, 16'h0007, 4'h6, 16'h0000}};

  always #2 clk = ~clk;

  sector_status_regs i_sector_status_regs (
    .REF_CLK(clk), .SYS_RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
    .REG_RDATA(rdata), .CTL_ERASE_RUN(run), .CTL_SUSPEND(susp), .CTL_OP_DONE(done),
    .CTL_OP_ERASE(ers), .CTL_ERR(err), .CTL_SECT_FAIL(fail), .PROG_WORD0(word0),
    .PROG_WORD1_LOW(word1), .ERASE_SEL(esel), .IRQ(irq));

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test

  task automatic cmp(string what, logic [31:0] ex, logic [31:0] got);
    checks++;
    if (got !== ex) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, ex, got);
    end
  endtask : cmp

  task automatic reg_wr(logic [3:0] a, logic [15:0] d);
    @(posedge clk) begin wr <= 1'b1; addr <= a; wdata <= d; end
    @(posedge clk) wr <= 1'b0;
  endtask : reg_wr

  // read data stands only in the cycle after the strobe, so look just after that edge
  task automatic reg_rd(logic [3:0] a, logic [15:0] ex);
    @(posedge clk) begin rd <= 1'b1; addr <= a; end
    @(posedge clk) rd <= 1'b0;
    #1 cmp($sformatf("read %h", a), {16'h0000, ex}, {16'h0000, rdata});
    @(posedge clk) #1 cmp("read idle", 32'd0, {16'h0000, rdata});
  endtask : reg_rd

  // one-cycle end-of-operation pulse with its qualifiers
  task automatic op_end(logic is_erase, logic is_err);
    @(posedge clk) begin done <= 1'b1; ers <= is_erase; err <= is_err; end
    @(posedge clk) done <= 1'b0;
  endtask : op_end

  // hang guard, under two hundred cycles is the whole run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      finish_test();
    end
  end

  initial begin
    repeat (7) @(posedge clk);
    #1 cmp("irq in reset", 32'd0, {31'd0, irq});
    cmp("rdata in reset", 32'd0, {16'h0000, rdata});
    cmp("word0 in reset", 32'd0, word0);
    @(posedge clk) rst <= 1'b0;
    for (int a = 0; a < 8; a++) reg_rd(a[3:0], 16'h0000);
    foreach (rows[i]) begin
      reg_wr(rows[i].wa, rows[i].wd);
      reg_rd(rows[i].ra, rows[i].ex);
    end
    cmp("word0", 32'hABCD_1234, word0);
    cmp("word1", {16'h0000, 16'h5678}, {16'h0000, word1});
    cmp("erase sel", {20'h0_0000, 12'h800}, {20'h0_0000, esel});
    // suspend with sector 0 selected and marked
    reg_wr(4'h0, 16'h0001);
    reg_wr(4'h1, 16'h0000);
    @(posedge clk) begin susp <= 1'b1; fail <= 12'h001; end
    @(posedge clk) susp <= 1'b0;
    reg_wr(4'h0, 16'h0000);
    reg_rd(4'h0, 16'h0001);
    reg_rd(4'h1, 16'h0300);
    reg_rd(4'h5, 16'h0004);
    // clean program end clears sector status but keeps the bank bit
    op_end(1'b0, 1'b0);
    reg_rd(4'h0, 16'h0000);
    reg_rd(4'h1, 16'h0300);
    reg_rd(4'h5, 16'h0005);
    reg_wr(4'h6, 16'h0007);
    // erase ending in error, unselected sector 5 must not show
    reg_wr(4'h0, 16'h0008);
    reg_wr(4'h1, 16'h0001);
    @(posedge clk) begin run <= 1'b1; fail <= 12'h428; end
    op_end(1'b1, 1'b1);
    @(posedge clk) run <= 1'b0;
    reg_wr(4'h0, 16'h0000);
    reg_rd(4'h0, 16'h0408);
    reg_rd(4'h1, 16'h0301);
    reg_rd(4'h5, 16'h0002);
    reg_wr(4'h7, 16'h0002);
    #1 cmp("irq on", 32'd1, {31'd0, irq});
    reg_wr(4'h6, 16'h0002);
    #1 cmp("irq cleared", 32'd0, {31'd0, irq});
    // clean erase end clears everything and flags bit 0; sector 3 is marked
    // while running so the bank bit is set and the clean end must drop it
    reg_wr(4'h0, 16'h0008);
    @(posedge clk) begin run <= 1'b1; fail <= 12'h008; end
    op_end(1'b1, 1'b0);
    @(posedge clk) run <= 1'b0;
    reg_rd(4'h0, 16'h0000);
    reg_rd(4'h1, 16'h0000);
    cmp("erase sel", 32'd0, {20'h0_0000, esel});
    reg_rd(4'h5, 16'h0001);
    reg_wr(4'h7, 16'h0001);
    #1 cmp("irq done", 32'd1, {31'd0, irq});
    // second reset in mid-run drops every register and the interrupt
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    #1 cmp("irq mid reset", 32'd0, {31'd0, irq});
    cmp("esel mid reset", 32'd0, {20'h0_0000, esel});
    @(posedge clk) rst <= 1'b0;
    for (int a = 0; a < 8; a++) reg_rd(a[3:0], 16'h0000);
    cmp("word0 mid reset", 32'd0, word0);
    finish_test();
  end
endmodule : sector_status_regs_tb_top
`default_nettype wire
